// ==== speed_profile_regs.svh ====
// Command codes and constants for the speed-profile block
`ifndef SPEED_PROFILE_REGS_SVH
`define SPEED_PROFILE_REGS_SVH
`define CMD_WR_MOVE 8'h80
`define CMD_WR_FL 8'h81
`define CMD_WR_FH 8'h82
`define CMD_WR_UR 8'h83
`define CMD_WR_DR 8'h84
`define CMD_WR_MG 8'h85
`define CMD_WR_DP 8'h86
`define CMD_WR_US 8'h89
`define CMD_WR_DS 8'h8a
`define CMD_RD_MOVE 8'hc0
`define CMD_RD_FL 8'hc1
`define CMD_RD_FH 8'hc2
`define CMD_RD_UR 8'hc3
`define CMD_RD_DR 8'hc4
`define CMD_RD_MG 8'hc5
`define CMD_RD_DP 8'hc6
`define CMD_RD_US 8'hc9
`define CMD_RD_DS 8'hca
`define CMD_RD_REMAIN 8'hf4
`define CMD_RD_SPEED 8'hf5
`define CMD_RD_RAMPPT 8'hf6
`define CMD_STOP_NOW 8'h49
`define CMD_STOP_RAMP 8'h4a
`define RAMP_TICK_MUL 18'h4
`define MOVE_SIGN_BIT 27
`endif

// ==== speed_profile_pkg.sv ====
// Types shared by the speed-profile modules
package speed_profile_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACCEL = 3'b001,
      ST_RUN = 3'b010,
      ST_DECEL = 3'b011,
      ST_LOW = 3'b100
   } move_state_t;
   typedef struct packed {
      logic [27:0] pre_mv;
      logic [15:0] pre_fl;
      logic [15:0] pre_fh;
      logic [15:0] pre_ur;
      logic [15:0] pre_dr;
      logic [11:0] pre_mg;
      logic [23:0] pre_dp;
      logic [14:0] pre_us;
      logic [14:0] pre_ds;
      logic [15:0] wk_fl;
      logic [15:0] wk_fh;
      logic [15:0] wk_ur;
      logic [15:0] wk_dr;
      logic [11:0] wk_mg;
      logic [23:0] wk_dp;
      logic [15:0] wk_sa;
      logic [15:0] wk_sd;
      logic wk_shape;
      logic wk_manual;
      move_state_t state;
      logic [15:0] speed;
      logic [15:0] frac;
      logic [15:0] jerk;
      logic [15:0] jerk_max;
      logic [27:0] remain;
      logic [27:0] auto_pt;
      logic [17:0] pt_acc;
      logic stop_req;
      logic dir;
      logic busy;
      logic pulse;
      logic [31:0] rdata;
   } core_state_t;
   typedef struct packed {
      logic [11:0] pres;
      logic [16:0] acc;
      logic pulse;
   } rate_state_t;
   typedef struct packed {
      logic [17:0] cnt;
      logic tick;
   } tick_state_t;
endpackage

// ==== profile_if.sv ====
// Signals between the profile core and its rate and ramp timers
`timescale 1ns/1ps
`default_nettype none
interface profile_if;
   logic [15:0] speed;
   logic [11:0] scale;
   logic [15:0] rate;
   logic run;
   logic pulse;
   logic tick;
   modport gen (input speed, input scale, input run, output pulse);
   modport tim (input rate, input run, output tick);
   modport ctl (output speed, output scale, output rate, output run, input pulse, input tick);
endinterface
`default_nettype wire

// ==== rate_pulse_gen.sv ====
// Output pulse rate generator: speed value scaled by magnification
`timescale 1ns/1ps
`default_nettype none
module rate_pulse_gen (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   profile_if.gen pif
);
   import speed_profile_pkg::*;
   rate_state_t r_reg;
   rate_state_t r_next;

   // Prescale by scale+1, then add speed into a 16-bit phase; carry is a pulse
   always_comb begin
      r_next = r_reg;
      r_next.pulse = 1'b0;
      if (!pif.run) begin
         r_next.pres = '0;
         r_next.acc = '0;
      end else if (r_reg.pres >= pif.scale) begin
         r_next.pres = '0;
         r_next.acc = {1'b0, r_reg.acc[15:0]} + {1'b0, pif.speed};
         r_next.pulse = r_next.acc[16];
      end else begin
         r_next.pres = r_reg.pres + 12'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign pif.pulse = r_reg.pulse;

   a_scale_period: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      r_reg.pulse |-> $past(r_reg.pres) >= $past(pif.scale))
      else $error("pulse outside scale boundary");
endmodule // rate_pulse_gen
`default_nettype wire

// ==== ramp_tick_gen.sv ====
// Ramp step timer: one tick every (rate+1)*4 clocks
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_regs.svh"
module ramp_tick_gen (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   profile_if.tim pif
);
   import speed_profile_pkg::*;
   tick_state_t t_reg;
   tick_state_t t_next;
   logic [17:0] lim;

   // Period in clocks is (rate+1)*4
   always_comb begin
      lim = 18'(({2'b00, pif.rate} + 18'h1) * `RAMP_TICK_MUL - 18'h1);
      t_next = t_reg;
      t_next.tick = 1'b0;
      if (!pif.run) begin
         t_next.cnt = '0;
      end else if (t_reg.cnt >= lim) begin
         t_next.cnt = '0;
         t_next.tick = 1'b1;
      end else begin
         t_next.cnt = t_reg.cnt + 18'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign pif.tick = t_reg.tick;

   a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      t_reg.tick |-> $past(t_reg.cnt) >= $past(lim))
      else $error("ramp tick came early");
endmodule // ramp_tick_gen
`default_nettype wire

// ==== accel_decel_speed_profile.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_regs.svh"
module accel_decel_speed_profile (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [31:0] cmd_data_i,
   input wire logic start_i,
   input wire logic curve_shape_select_i,
   input wire logic ramp_point_manual_select_i,
   output logic [31:0] rdata_o,
   output logic pulse_o,
   output logic dir_o,
   output logic busy_o,
   output logic [15:0] speed_o
);
   import speed_profile_pkg::*;

   speed_profile_pkg::core_state_t s_reg;
   speed_profile_pkg::core_state_t s_next;
   profile_if pif ();
   logic [27:0] mv_mag;
   logic [16:0] frac_sum;
   logic frac_carry;
   logic [17:0] pt_sum;
   logic [17:0] ur_one;
   logic signed [28:0] ramp_pt;
   logic signed [28:0] remain_s;

   // Zero range falls back to half the span, never below one step
   function automatic logic [15:0] s_range(input logic [14:0] s,
                                           input logic [15:0] fh,
                                           input logic [15:0] fl);
      logic [15:0] half;
      half = (fh - fl) >> 1;
      if (s != '0) begin
         return {1'b0, s};
      end
      return (half == '0) ? 16'h1 : half;
   endfunction

   // S zones step every other tick, so each zone costs twice its span in ticks
   function automatic logic [15:0] step_div(input logic shape,
                                            input logic [15:0] v,
                                            input logic [15:0] fl,
                                            input logic [15:0] fh,
                                            input logic [15:0] s);
      logic zone;
      zone = ({1'b0, v} < ({1'b0, fl} + {1'b0, s})) || (({1'b0, v} + {1'b0, s}) >= {1'b0, fh});
      return (shape && zone) ? 16'h2 : 16'h1;
   endfunction

   rate_pulse_gen u_rate (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .pif(pif.gen)
   );

   ramp_tick_gen u_tick (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .pif(pif.tim)
   );

   // Timers run from the working copy only
   assign pif.speed = s_reg.speed;
   assign pif.scale = s_reg.wk_mg;
   assign pif.rate = (s_reg.state == ST_DECEL) ? s_reg.wk_dr : s_reg.wk_ur;
   assign pif.run = s_reg.busy;

   // Helper terms for stepping and the ramp point
   always_comb begin
      mv_mag = s_reg.pre_mv[`MOVE_SIGN_BIT] ? 28'(-s_reg.pre_mv) : s_reg.pre_mv;
      frac_sum = {1'b0, s_reg.frac} + {1'b0, s_reg.jerk};
      frac_carry = frac_sum >= {1'b0, s_reg.jerk_max};
      ur_one = {2'b00, s_reg.wk_ur} + 18'h1;
      pt_sum = s_reg.pt_acc + {2'b00, s_reg.wk_dr} + 18'h1;
      remain_s = $signed({1'b0, s_reg.remain});
      if (s_reg.wk_manual) begin
         ramp_pt = $signed({5'b00000, s_reg.wk_dp});
      end else begin
         ramp_pt = $signed({1'b0, s_reg.auto_pt}) + 29'(signed'(s_reg.wk_dp));
      end
   end

   // Profile sequencer, host commands and read-back
   always_comb begin
      s_next = s_reg;
      s_next.pulse = 1'b0;
      case (s_reg.state)
         ST_IDLE: begin
            if (start_i && mv_mag != '0) begin
               s_next.wk_fl = s_reg.pre_fl;
               s_next.wk_fh = s_reg.pre_fh;
               s_next.wk_ur = s_reg.pre_ur;
               s_next.wk_dr = (s_reg.pre_dr == '0) ? s_reg.pre_ur : s_reg.pre_dr;
               s_next.wk_mg = s_reg.pre_mg;
               s_next.wk_dp = s_reg.pre_dp;
               s_next.wk_sa = s_range(s_reg.pre_us, s_reg.pre_fh, s_reg.pre_fl);
               s_next.wk_sd = s_range(s_reg.pre_ds, s_reg.pre_fh, s_reg.pre_fl);
               s_next.wk_shape = curve_shape_select_i;
               s_next.wk_manual = ramp_point_manual_select_i;
               s_next.remain = mv_mag;
               s_next.dir = s_reg.pre_mv[`MOVE_SIGN_BIT];
               s_next.speed = s_reg.pre_fl;
               s_next.frac = '0;
               s_next.jerk = 16'h1;
               // Linear steps once per tick; S zones at half rate
               s_next.jerk_max = step_div(curve_shape_select_i, s_reg.pre_fl, s_reg.pre_fl,
                  s_reg.pre_fh, s_range(s_reg.pre_us, s_reg.pre_fh, s_reg.pre_fl));
               s_next.auto_pt = '0;
               s_next.pt_acc = '0;
               s_next.stop_req = 1'b0;
               // Equal or lower run speed just runs at start speed
               s_next.state = (s_reg.pre_fh > s_reg.pre_fl) ? ST_ACCEL : ST_LOW;
            end
         end
         ST_ACCEL: begin
            if (pif.tick) begin
               s_next.frac = frac_carry ? 16'(frac_sum - {1'b0, s_reg.jerk_max}) :
                  frac_sum[15:0];
               if (frac_carry) begin
                  s_next.speed = s_reg.speed + 16'h1;
               end
               if (s_next.speed >= s_reg.wk_fh) begin
                  s_next.speed = s_reg.wk_fh;
                  s_next.state = ST_RUN;
               end
               // Divider for the next step, from the speed it starts at
               s_next.jerk_max = step_div(s_reg.wk_shape, s_next.speed, s_reg.wk_fl,
                  s_reg.wk_fh, s_reg.wk_sa);
            end
         end
         ST_RUN: begin
         end
         ST_DECEL: begin
            if (pif.tick) begin
               s_next.frac = frac_carry ? 16'(frac_sum - {1'b0, s_reg.jerk_max}) :
                  frac_sum[15:0];
               if (frac_carry) begin
                  s_next.speed = s_reg.speed - 16'h1;
               end
               s_next.jerk_max = step_div(s_reg.wk_shape, s_next.speed - 16'h1, s_reg.wk_fl,
                  s_reg.wk_fh, s_reg.wk_sd);
               if (s_next.speed <= s_reg.wk_fl) begin
                  s_next.speed = s_reg.wk_fl;
                  s_next.state = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            // Ramped stop ends once back at start speed
            if (s_reg.stop_req) begin
               s_next.state = ST_IDLE;
            end
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase
      // Enter deceleration at the ramp point or on a ramped stop
      if ((s_reg.state == ST_ACCEL || s_reg.state == ST_RUN) &&
          (remain_s <= ramp_pt || s_reg.stop_req)) begin
         s_next.state = ST_DECEL;
         s_next.frac = '0;
         s_next.jerk = 16'h1;
         s_next.jerk_max = step_div(s_reg.wk_shape, s_reg.speed - 16'h1, s_reg.wk_fl,
            s_reg.wk_fh, s_reg.wk_sd);
      end
      // Count output pulses; auto point learns decel span during accel
      if (pif.pulse && s_reg.state != ST_IDLE) begin
         s_next.pulse = 1'b1;
         s_next.remain = s_reg.remain - 28'h1;
         if (s_reg.state == ST_ACCEL) begin
            // Weight by decel over accel rate; ratio above two drifts
            if (pt_sum >= 18'(ur_one << 1)) begin
               s_next.pt_acc = 18'(pt_sum - (ur_one << 1));
               s_next.auto_pt = s_reg.auto_pt + 28'h2;
            end else if (pt_sum >= ur_one) begin
               s_next.pt_acc = pt_sum - ur_one;
               s_next.auto_pt = s_reg.auto_pt + 28'h1;
            end else begin
               s_next.pt_acc = pt_sum;
            end
         end
         if (s_reg.remain == 28'h1) begin
            s_next.state = ST_IDLE;
         end
      end
      // Host commands; pre-registers never touch a running move
      if (cmd_valid_i) begin
         case (cmd_code_i)
            `CMD_WR_MOVE: s_next.pre_mv = cmd_data_i[27:0];
            `CMD_WR_FL: s_next.pre_fl = cmd_data_i[15:0];
            `CMD_WR_FH: s_next.pre_fh = cmd_data_i[15:0];
            `CMD_WR_UR: s_next.pre_ur = cmd_data_i[15:0];
            `CMD_WR_DR: s_next.pre_dr = cmd_data_i[15:0];
            `CMD_WR_MG: s_next.pre_mg = cmd_data_i[11:0];
            `CMD_WR_DP: s_next.pre_dp = cmd_data_i[23:0];
            `CMD_WR_US: s_next.pre_us = cmd_data_i[14:0];
            `CMD_WR_DS: s_next.pre_ds = cmd_data_i[14:0];
            `CMD_RD_MOVE: s_next.rdata = {{4{s_reg.pre_mv[`MOVE_SIGN_BIT]}}, s_reg.pre_mv};
            `CMD_RD_FL: s_next.rdata = {16'h0, s_reg.pre_fl};
            `CMD_RD_FH: s_next.rdata = {16'h0, s_reg.pre_fh};
            `CMD_RD_UR: s_next.rdata = {16'h0, s_reg.pre_ur};
            `CMD_RD_DR: s_next.rdata = {16'h0, s_reg.pre_dr};
            `CMD_RD_MG: s_next.rdata = {20'h0, s_reg.pre_mg};
            `CMD_RD_DP: s_next.rdata = {8'h0, s_reg.pre_dp};
            `CMD_RD_US: s_next.rdata = {17'h0, s_reg.pre_us};
            `CMD_RD_DS: s_next.rdata = {17'h0, s_reg.pre_ds};
            `CMD_RD_REMAIN: s_next.rdata = {4'h0, s_reg.remain};
            `CMD_RD_SPEED: s_next.rdata = {16'h0, s_reg.speed};
            `CMD_RD_RAMPPT: s_next.rdata = 32'(ramp_pt);
            `CMD_STOP_NOW: s_next.state = ST_IDLE;
            `CMD_STOP_RAMP: s_next.stop_req = s_reg.busy;
            default: begin
            end
         endcase
      end
      // Idle shows zero speed and no activity
      s_next.busy = (s_next.state != ST_IDLE);
      if (s_next.state == ST_IDLE) begin
         s_next.speed = '0;
         s_next.stop_req = 1'b0;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata;
   assign pulse_o = s_reg.pulse;
   assign dir_o = s_reg.dir;
   assign busy_o = s_reg.busy;
   assign speed_o = s_reg.speed;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_start_taken;
      s_reg.state == ST_IDLE && start_i && mv_mag != '0;
   endsequence

   sequence s_quiet_cycle;
      !cmd_valid_i && !pif.pulse;
   endsequence

   a_start_copy: assert property (s_start_taken and s_quiet_cycle |=>
      s_reg.wk_fh == $past(s_reg.pre_fh) && s_reg.speed == $past(s_reg.pre_fl) &&
      s_reg.wk_mg == $past(s_reg.pre_mg))
      else $error("working set not copied at start");

   a_decel_fallback: assert property (s_start_taken |=>
      s_reg.wk_dr == (($past(s_reg.pre_dr) == '0) ? $past(s_reg.pre_ur) : $past(s_reg.pre_dr)))
      else $error("decel rate fallback wrong");

   a_srange_zero: assert property (s_start_taken and
      (s_reg.pre_us == '0 && s_reg.pre_fh > s_reg.pre_fl + 16'h1) |=>
      s_reg.wk_sa == ($past(s_reg.pre_fh) - $past(s_reg.pre_fl)) >> 1)
      else $error("zero S range not halved");

   a_manual_point: assert property ((s_reg.state == ST_RUN && s_reg.wk_manual &&
      s_reg.remain <= {4'h0, s_reg.wk_dp}) ##0 s_quiet_cycle |=>
      s_reg.state == ST_DECEL)
      else $error("manual ramp point missed");

   a_auto_point: assert property ((s_reg.state == ST_RUN && !s_reg.wk_manual &&
      remain_s <= ramp_pt) ##0 s_quiet_cycle |=> s_reg.state == ST_DECEL)
      else $error("auto ramp point missed");

   a_decel_rate: assert property (s_reg.state == ST_DECEL |->
      pif.rate == s_reg.wk_dr)
      else $error("decel not timed by decel rate");

   a_speed_bounds: assert property (s_reg.state inside {ST_ACCEL, ST_RUN, ST_DECEL} |->
      s_reg.speed >= s_reg.wk_fl && s_reg.speed <= s_reg.wk_fh)
      else $error("speed left the start/run window");

   a_linear_tick: assert property ((s_reg.state == ST_ACCEL && !s_reg.wk_shape && !pif.tick)
      ##1 (s_reg.state == ST_ACCEL) |-> s_reg.speed == $past(s_reg.speed))
      else $error("linear speed moved between ticks");

   a_linear_step: assert property ((s_reg.state == ST_ACCEL && !s_reg.wk_shape && pif.tick &&
      s_reg.speed < s_reg.wk_fh) ##0 s_quiet_cycle |=> s_reg.speed == $past(s_reg.speed) + 16'h1)
      else $error("linear step not one per tick");
endmodule // accel_decel_speed_profile
`default_nettype wire

// ==== host_cmd_model.sv ====
// Host model: command strobes, register reads and move starts
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
   input wire logic sys_clk_i,
   input wire logic [31:0] rdata_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_code_o,
   output logic [31:0] cmd_data_o,
   output logic start_o,
   output logic shape_o,
   output logic manual_o
);
   // Quiet bus from time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_data_o = 32'h0;
      start_o = 1'b0;
      shape_o = 1'b0;
      manual_o = 1'b0;
   end

   // One-cycle strobe; data inverted after so a stale word never looks valid
   task automatic send(input logic [7:0] code, input logic [31:0] data);
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = code;
      cmd_data_o = data;
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b0;
      cmd_data_o = ~data;
   endtask

   // Answer lands at the taking edge; sampled one negedge after the strobe drops
   task automatic read(input logic [7:0] code, output logic [31:0] data);
      send(code, 32'h0);
      @(negedge sys_clk_i);
      data = rdata_i;
   endtask

   // Selects only promised at the sampling edge, flipped afterwards
   task automatic go(input logic shape, input logic manual);
      @(negedge sys_clk_i);
      start_o = 1'b1;
      shape_o = shape;
      manual_o = manual;
      @(negedge sys_clk_i);
      start_o = 1'b0;
      shape_o = ~shape;
      manual_o = ~manual;
   endtask
endmodule // host_cmd_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the speed-profile block
`timescale 1ns/1ps
`default_nettype none
`include "speed_profile_regs.svh"
module tb;
   typedef struct {logic [7:0] wr; logic [7:0] rd; logic [31:0] d; logic [31:0] e;} reg_row_t;
   typedef struct {logic sh; logic man; logic [15:0] us; logic [15:0] ds; logic [15:0] ur;
      logic [15:0] dr; logic [31:0] mv; int ta; int td;} move_row_t;
   localparam logic [15:0] lo_spd = 16'h8000;
   localparam logic [15:0] hi_spd = 16'h8003;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid, start, shape, manual, pulse, dir, busy;
   logic [7:0] cmd_code;
   logic [31:0] cmd_data, rdata, rd;
   logic [15:0] speed;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   int t0, t1, t2, t3;
   // Writes, oversize except DR and MOVE, read back at register width; MOVE comes back sign-extended
   reg_row_t regs [9] = '{
      '{`CMD_WR_FL, `CMD_RD_FL, 32'hffff_ffff, 32'h0000_ffff},
      '{`CMD_WR_FH, `CMD_RD_FH, 32'h1234_0001, 32'h0000_0001},
      '{`CMD_WR_UR, `CMD_RD_UR, 32'h0001_ffff, 32'h0000_ffff},
      '{`CMD_WR_DR, `CMD_RD_DR, 32'h0000_0000, 32'h0000_0000},
      '{`CMD_WR_MG, `CMD_RD_MG, 32'hffff_f002, 32'h0000_0002},
      '{`CMD_WR_DP, `CMD_RD_DP, 32'hff80_0000, 32'h0080_0000},
      '{`CMD_WR_US, `CMD_RD_US, 32'hffff_ffff, 32'h0000_7fff},
      '{`CMD_WR_DS, `CMD_RD_DS, 32'h0000_8001, 32'h0000_0001},
      '{`CMD_WR_MOVE, `CMD_RD_MOVE, 32'h0800_0000, 32'hf800_0000}
   };
   // Shape, ramp mode, ranges, rates, move, expected ramp cycles
   move_row_t moves [5] = '{
      '{1'b0, 1'b1, 16'h0, 16'h0, 16'h1, 16'h3, 32'd60, 24, 48},
      '{1'b0, 1'b1, 16'h0, 16'h0, 16'h2, 16'h0, 32'd60, 36, 36},
      '{1'b0, 1'b0, 16'h0, 16'h0, 16'h1, 16'h2, 32'd60, 24, 36},
      '{1'b1, 1'b1, 16'h0, 16'h0, 16'h1, 16'h1, 32'd60, 48, 48},
      '{1'b1, 1'b1, 16'h1, 16'h1, 16'h1, 16'h1, 32'hffff_ffc4, 40, 40}
   };

   accel_decel_speed_profile uut (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .start_i(start),
      .curve_shape_select_i(shape), .ramp_point_manual_select_i(manual), .rdata_o(rdata),
      .pulse_o(pulse), .dir_o(dir), .busy_o(busy), .speed_o(speed));
   host_cmd_model host (.sys_clk_i(sys_clk), .rdata_i(rdata), .cmd_valid_o(cmd_valid),
      .cmd_code_o(cmd_code), .cmd_data_o(cmd_data), .start_o(start), .shape_o(shape),
      .manual_o(manual));

   always #10 sys_clk = ~sys_clk;

   // Cycle count for timing, and hang cut-off well past the planned run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         results();
      end
   end

   // Running profile must ignore run speed rewritten mid-move
   always @(negedge sys_clk) begin
      if (busy === 1'b1 && speed > hi_spd) check("speed cap", {16'h0, hi_spd}, {16'h0, speed});
   end

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // S shapes are approximate by design, so durations get a window
   task automatic near(input string nm, input int e, input int g);
      comparisons++;
      if (g < e - e / 4 - 3 || g > e + e / 4 + 3) begin
         n_mismatch++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // Bounded wait for speed to reach (eq) or leave a value
   task automatic wait_spd(input logic [15:0] v, input bit eq, output int t);
      int n;
      n = 0;
      while (((speed === v) != eq) && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      t = cyc;
   endtask

   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      check("busy", {31'h0, v}, {31'h0, busy});
   endtask

   task automatic results();
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge sys_clk);
      arst_n = 1'b1;
      check("busy at reset", 32'h0, {31'h0, busy});
      check("speed at reset", 32'h0, {16'h0, speed});
      host.read(`CMD_RD_FH, rd);
      check("run speed reset", 32'h0, rd);
      foreach (regs[i]) begin
         host.send(regs[i].wr, regs[i].d);
         host.read(regs[i].rd, rd);
         check("register readback", regs[i].e, rd);
      end
      // Ramp timing table; ramp point is a count in manual mode, an offset in auto
      host.send(`CMD_WR_MG, 32'h2);
      host.send(`CMD_WR_DP, 32'd16);
      foreach (moves[i]) begin
         host.send(`CMD_WR_FL, {16'h0, lo_spd});
         host.send(`CMD_WR_FH, {16'h0, hi_spd});
         host.send(`CMD_WR_UR, {16'h0, moves[i].ur});
         host.send(`CMD_WR_DR, {16'h0, moves[i].dr});
         host.send(`CMD_WR_US, {16'h0, moves[i].us});
         host.send(`CMD_WR_DS, {16'h0, moves[i].ds});
         host.send(`CMD_WR_MOVE, moves[i].mv);
         host.go(moves[i].sh, moves[i].man);
         wait_busy(1'b1, 3);
         t0 = cyc;
         check("start speed", {16'h0, lo_spd}, {16'h0, speed});
         check("direction", {31'h0, moves[i].mv[31]}, {31'h0, dir});
         host.send(`CMD_WR_FH, 32'hffff);
         wait_spd(hi_spd, 1'b1, t1);
         near("accel time", moves[i].ta, t1 - t0);
         wait_spd(hi_spd, 1'b0, t2);
         if (moves[i].man && !moves[i].mv[31]) begin
            host.read(`CMD_RD_REMAIN, rd);
            // A first decel tick and the read itself pass after the point
            check("ramp start", 32'h1, {31'h0, rd <= 32'd16 && rd >= 32'd12});
         end
         wait_spd(lo_spd, 1'b1, t3);
         // Decel entry is unseen: scale the later steps up to the whole span
         near("decel time", moves[i].td, (t3 - t2) * 3 / 2);
         wait_busy(1'b0, 600);
      end
      // Immediate stop in mid-acceleration
      host.send(`CMD_WR_FH, {16'h0, hi_spd});
      host.send(`CMD_WR_MOVE, 32'd4000);
      host.go(1'b0, 1'b1);
      wait_busy(1'b1, 3);
      host.send(`CMD_STOP_NOW, 32'h0);
      wait_busy(1'b0, 2);
      check("speed after stop", 32'h0, {16'h0, speed});
      // Ramp stop from run speed: linear, both rates 1
      host.send(`CMD_WR_MOVE, 32'd4000);
      host.go(1'b0, 1'b1);
      wait_spd(hi_spd, 1'b1, t1);
      host.send(`CMD_STOP_RAMP, 32'h0);
      t2 = cyc;
      wait_spd(lo_spd, 1'b1, t3);
      near("ramp stop time", 24, t3 - t2);
      wait_busy(1'b0, 8);
      // Reset in mid-move clears motion and pre-registers
      host.go(1'b0, 1'b1);
      wait_busy(1'b1, 3);
      arst_n = 1'b0;
      #1;
      check("busy in reset", 32'h0, {31'h0, busy});
      check("speed in reset", 32'h0, {16'h0, speed});
      @(negedge sys_clk);
      arst_n = 1'b1;
      host.read(`CMD_RD_FL, rd);
      check("start speed after reset", 32'h0, rd);
      results();
   end
endmodule // tb
`default_nettype wire
